/* File: rtl/encoder_pulse_counter_params.svh */
`ifndef ENCODER_PULSE_COUNTER_PARAMS_SVH
`define ENCODER_PULSE_COUNTER_PARAMS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define EPC_OFF_CTRL      12'h000
`define EPC_OFF_TARGET    12'h004
`define EPC_OFF_PRELOAD   12'h008
`define EPC_OFF_RESTART   12'h00C
`define EPC_OFF_COUNT     12'h010
`define EPC_OFF_CAPTURED  12'h014
`define EPC_OFF_STATUS    12'h018
`define EPC_OFF_IRQ_EN    12'h01C
`define EPC_OFF_IRQ_CLR   12'h020
`define EPC_OFF_SCAN_DIV  12'h024

// ****************************************
// control register fields
// ****************************************
`define EPC_CTRL_ENABLE    0
`define EPC_CTRL_PRELOAD   1
`define EPC_CTRL_SW_CLEAR  2
`define EPC_CTRL_SW_SAVE   3
`define EPC_CTRL_SRC_LO    4
`define EPC_CTRL_SRC_HI    6
`define EPC_CTRL_CLR_LO    8
`define EPC_CTRL_CLR_HI    11
`define EPC_CTRL_SAVE_LO   12
`define EPC_CTRL_SAVE_HI   15
`define EPC_CTRL_RST       32'h0000_0000

// ****************************************
// status / interrupt bit positions
// ****************************************
`define EPC_ST_REACHED     0
`define EPC_ST_CLEARED     1
`define EPC_ST_CAPTURED    2
`define EPC_ST_WIDTH       3

// ****************************************
// misc reset values
// ****************************************
`define EPC_SCAN_DIV_RST   32'h0000_0013
`define EPC_ZERO32         32'h0000_0000

`endif

/* File: rtl/encoder_pulse_counter_pkg.sv */
package encoder_pulse_counter_pkg;

	// counting mode, fixed at build time
	typedef enum logic {
		count_quadrature,
		count_pulse_dir
	} count_mode_e;

	// encoder that feeds the counter
	typedef enum logic [2:0] {
		src_main,
		src_aux,
		src_quick_counter,
		src_expansion_one,
		src_expansion_two
	} encoder_src_e;

	// clear or save event source
	typedef enum logic [3:0] {
		ev_none,
		ev_level,
		ev_main_index,
		ev_di3_rise,
		ev_di3_fall,
		ev_z1_rise,
		ev_z1_fall,
		ev_z2_rise,
		ev_z2_fall
	} event_src_e;

endpackage : encoder_pulse_counter_pkg

/* File: rtl/quad_step_if.sv */
`timescale 1ns/10ps
`default_nettype none

// one decoded counting step from an encoder channel pair
interface quad_step_if;
	logic up;
	logic down;
	logic index_rise;
	logic index_fall;

	modport producer (output up, output down, output index_rise, output index_fall);
	modport consumer (input up, input down, input index_rise, input index_fall);
endinterface : quad_step_if

`default_nettype wire

/* File: rtl/quad_decoder.sv */
`timescale 1ns/10ps
`default_nettype none

module quad_decoder
	import encoder_pulse_counter_pkg::*;
#(
	parameter count_mode_e MODE = count_quadrature
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// raw encoder channels
	input  wire logic ch_a,
	input  wire logic ch_b,
	input  wire logic ch_z,
	// decoded steps
	quad_step_if.producer step
);

	// ****************************************
	// synchronisers and history
	// ****************************************
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] last;

	// two flops per channel, third stage is edge history
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			last  <= 3'h0;
		end else begin
			sync1 <= {ch_z, ch_b, ch_a};
			sync2 <= sync1;
			last  <= sync2;
		end
	end

	// ****************************************
	// step decoding
	// ****************************************
	wire a_now    = sync2[0];
	wire b_now    = sync2[1];
	wire a_edge   = sync2[0] ^ last[0];
	wire b_edge   = sync2[1] ^ last[1];
	wire a_rise   = sync2[0] & ~last[0];
	// a pair of simultaneous edges is a glitch or skip: ignored, not guessed
	wire quad_ok  = a_edge ^ b_edge;
	wire quad_dir = a_edge ? (a_now ^ b_now) : ~(a_now ^ b_now);

	// quadrature counts every edge, pulse-dir counts rising a only
	assign step.up   = (MODE == count_quadrature) ? (quad_ok & quad_dir)
	                                              : (a_rise & b_now);
	assign step.down = (MODE == count_quadrature) ? (quad_ok & ~quad_dir)
	                                              : (a_rise & ~b_now);
	assign step.index_rise = sync2[2] & ~last[2];
	assign step.index_fall = ~sync2[2] & last[2];

endmodule : quad_decoder

`default_nettype wire

/* File: rtl/encoder_pulse_counter.sv */
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

`include "encoder_pulse_counter_params.svh"

module encoder_pulse_counter
	import encoder_pulse_counter_pkg::*;
#(
	parameter int          WIDTH    = 32,
	parameter count_mode_e MAIN_MODE = count_quadrature,
	parameter count_mode_e AUX_MODE  = count_quadrature
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	// encoder channels: main, auxiliary, quick pair, expansion one/two
	input  wire logic        main_a,
	input  wire logic        main_b,
	input  wire logic        main_z,
	input  wire logic        aux_a,
	input  wire logic        aux_b,
	input  wire logic        quick_a,
	input  wire logic        quick_b,
	input  wire logic        third_digital_input,
	input  wire logic        exp1_a,
	input  wire logic        exp1_b,
	input  wire logic        exp1_z,
	input  wire logic        exp2_a,
	input  wire logic        exp2_b,
	input  wire logic        exp2_z,
	// ladder-side level clear and save sources
	input  wire logic        clear_level,
	input  wire logic        save_level,
	// results
	output logic             count_reached,
	output logic             clear_happened_flag,
	output logic             capture_happened_flag,
	output logic             irq
);

	// ****************************************
	// encoder decoders
	// ****************************************
	// one step bundle per encoder input group
	quad_step_if s_main ();
	quad_step_if s_aux ();
	quad_step_if s_quick ();
	quad_step_if s_exp1 ();
	quad_step_if s_exp2 ();

	// main encoder carries position feedback: quadrature only
	quad_decoder #(.MODE(count_quadrature)) u_main (
		.mclk(mclk), .nrst(nrst), .ch_a(main_a), .ch_b(main_b), .ch_z(main_z),
		.step(s_main.producer));
	// the auxiliary input has no index line
	quad_decoder #(.MODE(AUX_MODE)) u_aux (
		.mclk(mclk), .nrst(nrst), .ch_a(aux_a), .ch_b(aux_b), .ch_z(1'b0),
		.step(s_aux.producer));
	// third input rides on the quick pair's index slot for edge detection
	quad_decoder #(.MODE(MAIN_MODE)) u_quick (
		.mclk(mclk), .nrst(nrst), .ch_a(quick_a), .ch_b(quick_b),
		.ch_z(third_digital_input), .step(s_quick.producer));
	// expansion inputs share the auxiliary mode
	quad_decoder #(.MODE(AUX_MODE)) u_exp1 (
		.mclk(mclk), .nrst(nrst), .ch_a(exp1_a), .ch_b(exp1_b), .ch_z(exp1_z),
		.step(s_exp1.producer));
	quad_decoder #(.MODE(AUX_MODE)) u_exp2 (
		.mclk(mclk), .nrst(nrst), .ch_a(exp2_a), .ch_b(exp2_b), .ch_z(exp2_z),
		.step(s_exp2.producer));

	// ****************************************
	// registers
	// ****************************************
	logic [31:0]                ctrl;
	logic [WIDTH-1:0]           target_count;
	logic [WIDTH-1:0]           preload_value;
	logic [WIDTH-1:0]           restart_value;
	logic [WIDTH-1:0]           accumulated_count;
	logic [WIDTH-1:0]           captured_count;
	logic [`EPC_ST_WIDTH-1:0]   status;
	logic [`EPC_ST_WIDTH-1:0]   irq_en;
	logic [31:0]                scan_div;
	logic [31:0]                scan_cnt;
	// scan history and pending events
	logic                       enable_last;
	logic                       pend_up;
	logic                       pend_down;
	logic                       pend_clear;
	logic                       pend_save;
	logic                       reached_last;

	// ****************************************
	// control field decode
	// ****************************************
	// reserved control bits are stored but unused
	wire        enable    = ctrl[`EPC_CTRL_ENABLE];
	wire        preload   = ctrl[`EPC_CTRL_PRELOAD];
	wire [2:0]  src_raw   = ctrl[`EPC_CTRL_SRC_HI:`EPC_CTRL_SRC_LO];
	wire [3:0]  clr_raw   = ctrl[`EPC_CTRL_CLR_HI:`EPC_CTRL_CLR_LO];
	wire [3:0]  save_raw  = ctrl[`EPC_CTRL_SAVE_HI:`EPC_CTRL_SAVE_LO];
	wire        src_quick = (src_raw == src_quick_counter);
	wire        src_exp   = (src_raw == src_expansion_one) | (src_raw == src_expansion_two);

	// selected encoder's steps
	// unused source codes select no steps
	wire step_up   = (src_raw == src_main)          ? s_main.up  :
	                 (src_raw == src_aux)           ? s_aux.up   :
	                 (src_raw == src_quick_counter) ? s_quick.up :
	                 (src_raw == src_expansion_one) ? s_exp1.up  :
	                 (src_raw == src_expansion_two) ? s_exp2.up  : 1'b0;
	wire step_down = (src_raw == src_main)          ? s_main.down  :
	                 (src_raw == src_aux)           ? s_aux.down   :
	                 (src_raw == src_quick_counter) ? s_quick.down :
	                 (src_raw == src_expansion_one) ? s_exp1.down  :
	                 (src_raw == src_expansion_two) ? s_exp2.down  : 1'b0;

	// event source decode; DI3 edges need the quick source, Z1/Z2 edges either expansion source, main index none
	// one decode serves both clear and save
	function automatic logic event_hit(input logic [3:0] sel, input logic lvl);
		case (sel)
			ev_level:      event_hit = lvl;
			ev_main_index: event_hit = s_main.index_rise;
			ev_di3_rise:   event_hit = src_quick & s_quick.index_rise;
			ev_di3_fall:   event_hit = src_quick & s_quick.index_fall;
			ev_z1_rise:    event_hit = src_exp & s_exp1.index_rise;
			ev_z1_fall:    event_hit = src_exp & s_exp1.index_fall;
			ev_z2_rise:    event_hit = src_exp & s_exp2.index_rise;
			ev_z2_fall:    event_hit = src_exp & s_exp2.index_fall;
			default:       event_hit = 1'b0;
		endcase
	endfunction : event_hit

	// a level source is the pin or the strobe bit
	wire clear_ev  = event_hit(clr_raw, clear_level | ctrl[`EPC_CTRL_SW_CLEAR]);
	wire save_ev   = event_hit(save_raw, save_level | ctrl[`EPC_CTRL_SW_SAVE]);

	// ****************************************
	// scan strobe
	// ****************************************
	// >= so a divider lowered below the running count
	// strobes at once instead of after a wrap
	wire scan = (scan_cnt >= scan_div);

	// free-running scan divider
	// one scan of the ladder program is scan_div + 1 clocks
	always_ff @(posedge mclk) begin
		if (!nrst)
			scan_cnt <= `EPC_ZERO32;
		else
			scan_cnt <= scan ? `EPC_ZERO32 : scan_cnt + 32'h0000_0001;
	end

	// clear and save events pile up between scans so none is lost;
	// a scan uses the live event and drops the pending copy,
	// so no event acts in two scans
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pend_up    <= 1'b0;
			pend_down  <= 1'b0;
			pend_clear <= 1'b0;
			pend_save  <= 1'b0;
		end else begin
			pend_clear <= scan ? 1'b0 : (pend_clear | clear_ev);
			pend_save  <= scan ? 1'b0 : (pend_save | save_ev);
			pend_up    <= step_up;
			pend_down  <= step_down;
		end
	end

	// ****************************************
	// counter core
	// ****************************************
	// all controls but the enable-low count hold wait for a scan; with enable low
	// clears and saves are dropped, not held
	wire enable_rise = scan & enable & ~enable_last;
	wire do_clear    = scan & enable & (pend_clear | clear_ev);
	// a restart value of zero turns the wrap off
	wire at_restart  = (restart_value != {WIDTH{1'b0}}) && (accumulated_count == restart_value);
	wire do_restart  = scan & enable & at_restart;
	wire do_preload  = scan & enable & preload;
	wire do_save     = scan & enable & (pend_save | save_ev);
	// rearms once the count leaves the target
	wire reached     = (accumulated_count == target_count);
	wire next_reached_pulse = scan & enable & reached & ~reached_last;

	// priority: enable edge / clear / restart, then preload, then steps
	// a step landing in a clear or preload scan is lost
	wire [WIDTH-1:0] next_count =
		(enable_rise | do_clear | do_restart) ? {WIDTH{1'b0}} :
		do_preload                            ? preload_value :
		~enable                               ? accumulated_count :
		pend_up                               ? accumulated_count + {{(WIDTH-1){1'b0}}, 1'b1} :
		pend_down                             ? accumulated_count - {{(WIDTH-1){1'b0}}, 1'b1} :
		accumulated_count;

	// enable and reached history move only at a scan
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			accumulated_count <= {WIDTH{1'b0}};
			captured_count    <= {WIDTH{1'b0}};
			enable_last       <= 1'b0;
			reached_last      <= 1'b0;
		end else begin
			accumulated_count <= next_count;
			if (do_save)
				captured_count <= accumulated_count;
			if (scan) begin
				enable_last  <= enable;
				reached_last <= reached & enable;
			end
		end
	end

	// one-scan result pulses, registered for clean outputs
	// each flag stands one full scan period
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			count_reached         <= 1'b0;
			clear_happened_flag   <= 1'b0;
			capture_happened_flag <= 1'b0;
		end else if (scan) begin
			count_reached         <= next_reached_pulse;
			clear_happened_flag   <= do_clear | do_restart;
			capture_happened_flag <= do_save;
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	// writes land only at the completing edge: the
	// master holds through the wait state, so an
	// ungated strobe would write twice
	wire        wr_en   = psel & penable & pwrite & pready;
	wire        hit_ctl = (paddr == `EPC_OFF_CTRL);
	wire        hit_tgt = (paddr == `EPC_OFF_TARGET);
	wire        hit_pre = (paddr == `EPC_OFF_PRELOAD);
	wire        hit_rst = (paddr == `EPC_OFF_RESTART);
	wire        hit_cnt = (paddr == `EPC_OFF_COUNT);
	wire        hit_cap = (paddr == `EPC_OFF_CAPTURED);
	wire        hit_st  = (paddr == `EPC_OFF_STATUS);
	wire        hit_ie  = (paddr == `EPC_OFF_IRQ_EN);
	wire        hit_ic  = (paddr == `EPC_OFF_IRQ_CLR);
	wire        hit_div = (paddr == `EPC_OFF_SCAN_DIV);
	wire        mapped  = hit_ctl | hit_tgt | hit_pre | hit_rst | hit_cnt | hit_cap
	                      | hit_st | hit_ie | hit_ic | hit_div;
	// narrower counts read back zero-extended
	wire [31:0] rd_mux  =
		hit_ctl ? ctrl :
		hit_tgt ? 32'(target_count) :
		hit_pre ? 32'(preload_value) :
		hit_rst ? 32'(restart_value) :
		hit_cnt ? 32'(accumulated_count) :
		hit_cap ? 32'(captured_count) :
		hit_st  ? 32'(status) :
		hit_ie  ? 32'(irq_en) :
		hit_div ? scan_div : `EPC_ZERO32;   // clear register reads zero

	// software-written registers; strobe bits self-clear after one scan
	// control reads back as written, strobes aside
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ctrl          <= `EPC_CTRL_RST;
			target_count  <= {WIDTH{1'b0}};
			preload_value <= {WIDTH{1'b0}};
			restart_value <= {WIDTH{1'b0}};
			irq_en        <= {`EPC_ST_WIDTH{1'b0}};
			scan_div      <= `EPC_SCAN_DIV_RST;
		end else begin
			if (wr_en & hit_ctl)
				ctrl <= pwdata;
			else if (scan) begin
				ctrl[`EPC_CTRL_SW_CLEAR] <= 1'b0;
				ctrl[`EPC_CTRL_SW_SAVE]  <= 1'b0;
			end
			if (wr_en & hit_tgt)
				target_count <= pwdata[WIDTH-1:0];
			if (wr_en & hit_pre)
				preload_value <= pwdata[WIDTH-1:0];
			if (wr_en & hit_rst)
				restart_value <= pwdata[WIDTH-1:0];
			if (wr_en & hit_ie)
				irq_en <= pwdata[`EPC_ST_WIDTH-1:0];
			if (wr_en & hit_div)
				scan_div <= pwdata;
		end
	end

	// sticky status: a set in the clear cycle wins
	// irq follows status at once, an enable write a cycle later
	wire [`EPC_ST_WIDTH-1:0] st_set = {do_save, do_clear | do_restart, next_reached_pulse};
	wire [`EPC_ST_WIDTH-1:0] st_clr = (wr_en & hit_ic) ? pwdata[`EPC_ST_WIDTH-1:0]
	                                                   : {`EPC_ST_WIDTH{1'b0}};

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			status  <= {`EPC_ST_WIDTH{1'b0}};
			irq     <= 1'b0;
			pready  <= 1'b0;
			prdata  <= `EPC_ZERO32;
			pslverr <= 1'b0;
		end else begin
			status  <= (status & ~st_clr) | st_set;
			irq     <= |(((status & ~st_clr) | st_set) & irq_en);
			// one wait state: ready follows the first access cycle
			pready  <= psel & penable & ~pready;
			// reads sample in the access cycle; data is zero otherwise
			prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_mux : `EPC_ZERO32;
			// unmapped offsets answer with an error
			pslverr <= psel & penable & ~pready & ~mapped;
		end
	end

endmodule : encoder_pulse_counter

`default_nettype wire

/* File: dv/encoder_pulse_counter_asserts.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// port checker for the pulse counter
// ****************************************
module encoder_pulse_counter_asserts (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	// results
	input  wire logic        count_reached,
	input  wire logic        clear_happened_flag,
	input  wire logic        capture_happened_flag,
	input  wire logic        irq
);
	// one clock domain, so clock and reset are given once
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// bus answer: one wait state, one cycle wide, quiet data otherwise
	chk_ready_wait: assert property (psel && !penable |-> ##2 pready)
		else $error("pready missing two cycles after setup");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	chk_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("pready without an access phase");
	chk_data_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside a response");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error response without pready");
	// event flags last one clock cycle, as they do with scan_div at zero; otherwise each holds scan_div + 1 clocks
	chk_reached_once: assert property (count_reached |=> !count_reached)
		else $error("count reached wider than one cycle");
	chk_clear_once: assert property (clear_happened_flag |=> !clear_happened_flag)
		else $error("clear flag wider than one cycle");
	chk_capture_once: assert property (capture_happened_flag |=> !capture_happened_flag)
		else $error("capture flag wider than one cycle");
	// the interrupt only drops after software wrote something
	chk_irq_fall: assert property ($fell(irq) |-> $past(psel && pwrite))
		else $error("interrupt dropped without a write");
endmodule : encoder_pulse_counter_asserts

bind encoder_pulse_counter encoder_pulse_counter_asserts i_chk (
	.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .count_reached(count_reached),
	.clear_happened_flag(clear_happened_flag),
	.capture_happened_flag(capture_happened_flag), .irq(irq));

`default_nettype wire

/* File: dv/encoder_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// incremental encoder with index line
// ****************************************
module encoder_model (
	// clock
	input  wire logic mclk,
	// encoder lines
	output var logic  a,
	output var logic  b,
	output var logic  z
);
	logic [1:0] phase;  // position inside one quadrature cycle

	// an encoder always drives its lines, so they start at a known level
	initial begin
		phase = 2'b00;
		a = 1'b0;
		b = 1'b0;
		z = 1'b0;
	end

	// change just after an edge, then hold long enough to pass the synchroniser
	task automatic put(input logic na, input logic nb, input logic nz);
		@(posedge mclk);
		a <= na;
		b <= nb;
		z <= nz;
		repeat (5) @(posedge mclk);
	endtask : put

	// gray steps, a leads b when moving up
	task automatic quad(input int n, input logic up);
		for (int i = 0; i < n; i++) begin
			phase = up ? phase + 2'd1 : phase - 2'd1;
			put(phase[1] ^ phase[0], phase[1], 1'b0);
		end
	endtask : quad

	// direction level first, then whole pulses on a
	task automatic pulse(input int n, input logic up);
		put(1'b0, up, 1'b0);
		for (int i = 0; i < n; i++) begin
			put(1'b1, up, 1'b0);
			put(1'b0, up, 1'b0);
		end
	endtask : pulse

	// index pulse while a and b stand still
	task automatic index();
		put(a, b, 1'b1);
		put(a, b, 1'b0);
	endtask : index
endmodule : encoder_model

`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "encoder_pulse_counter_params.svh"

// ****************************************
// bench for the encoder pulse counter
// ****************************************
module tb_top;
	logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        main_a, main_b, main_z, aux_a, aux_b, quick_a, quick_b, third_digital_input;
	logic        exp1_a, exp1_b, exp1_z, exp2_a, exp2_b, exp2_z, clear_level, save_level;
	logic        count_reached, clear_happened_flag, capture_happened_flag, irq;
	int          bad_count = 0;
	int          num_checks = 0;
	int          reach_seen = 0, clear_seen = 0, save_seen = 0;

	// tally the one-scan result pulses for the scenarios
	always @(posedge mclk) begin
		reach_seen <= reach_seen + int'(count_reached);
		clear_seen <= clear_seen + int'(clear_happened_flag);
		save_seen  <= save_seen + int'(capture_happened_flag);
	end

	// aux and expansion inputs run pulse and direction
	encoder_pulse_counter #(
		.AUX_MODE(encoder_pulse_counter_pkg::count_pulse_dir)
	) i_encoder_pulse_counter (
		.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.main_a, .main_b, .main_z, .aux_a, .aux_b, .quick_a, .quick_b, .third_digital_input,
		.exp1_a, .exp1_b, .exp1_z, .exp2_a, .exp2_b, .exp2_z, .clear_level, .save_level,
		.count_reached, .clear_happened_flag, .capture_happened_flag, .irq);

	// one encoder per input group, so no encoder pin is tied off
	encoder_model i_enc_main (.mclk, .a(main_a), .b(main_b), .z(main_z));
	encoder_model i_enc_aux (.mclk, .a(aux_a), .b(aux_b), .z());
	encoder_model i_enc_quick (.mclk, .a(quick_a), .b(quick_b), .z(third_digital_input));
	encoder_model i_enc_exp1 (.mclk, .a(exp1_a), .b(exp1_b), .z(exp1_z));
	encoder_model i_enc_exp2 (.mclk, .a(exp2_a), .b(exp2_b), .z(exp2_z));

	// 20 MHz clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// a hang costs far more than the whole sequence needs
	initial begin
		repeat (40000) @(posedge mclk);
		bad_count++;
		summarize();
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// one transfer, held until pready; only the watchdog ends the wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		apb(1'b0, a, 32'h0000_0000, q);
		check(q, e);
	endtask : rd

	// control word with enable set; pc is {sw clear, preload}
	function automatic logic [31:0] ctrl(input logic [1:0] pc, input int src, input int cs,
			input int ss);
		return {16'h0000, 4'(ss), 4'(cs), 1'b0, 3'(src), 1'b0, pc, 1'b1};
	endfunction : ctrl

	initial begin
		int          n, m, t, c;
		logic [31:0] v;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		clear_level = 1'b0;
		save_level = 1'b0;
		void'($urandom(12214));
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		// reset values, an unmapped read, then a scan every cycle
		rd(`EPC_OFF_CTRL, `EPC_CTRL_RST);
		rd(`EPC_OFF_SCAN_DIV, `EPC_SCAN_DIV_RST);
		rd(`EPC_OFF_IRQ_EN, 32'h0000_0000);
		rd(12'h0FC, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001);
		wr(`EPC_OFF_SCAN_DIV, 32'h0000_0000);
		// main encoder forth and back, frozen while disabled, zeroed on enable
		n = 1 + $urandom % 12;
		m = $urandom % n;
		wr(`EPC_OFF_CTRL, ctrl(2'b00, 0, 0, 0));
		i_enc_main.quad(n, 1'b1);
		i_enc_main.quad(m, 1'b0);
		rd(`EPC_OFF_COUNT, 32'(n - m));
		wr(`EPC_OFF_CTRL, 32'h0000_0000);
		i_enc_main.quad(3, 1'b1);
		rd(`EPC_OFF_COUNT, 32'(n - m));
		wr(`EPC_OFF_CTRL, ctrl(2'b00, 0, 0, 0));
		rd(`EPC_OFF_COUNT, 32'h0000_0000);
		// target reached: status set, interrupt masked, raised, cleared
		t = 2 + $urandom % 8;
		wr(`EPC_OFF_TARGET, 32'(t));
		wr(`EPC_OFF_IRQ_CLR, 32'h0000_0007);
		i_enc_main.quad(t - 1, 1'b1);
		rd(`EPC_OFF_STATUS, 32'h0000_0000);
		c = reach_seen;
		i_enc_main.quad(1, 1'b1);
		rd(`EPC_OFF_STATUS, 32'h0000_0001);
		check(32'(reach_seen - c), 32'h0000_0001);
		check({31'h0, irq}, 32'h0000_0000);
		wr(`EPC_OFF_IRQ_EN, 32'h0000_0007);
		@(posedge mclk);
		check({31'h0, irq}, 32'h0000_0001);
		wr(`EPC_OFF_IRQ_CLR, 32'h0000_0001);
		check({31'h0, irq}, 32'h0000_0000);
		// preload pins the count against pulses; counting resumes after
		v = $urandom | 32'h0001_0000;
		wr(`EPC_OFF_PRELOAD, v);
		wr(`EPC_OFF_CTRL, ctrl(2'b01, 0, 0, 0));
		i_enc_main.quad(2, 1'b1);
		rd(`EPC_OFF_COUNT, v);
		wr(`EPC_OFF_CTRL, ctrl(2'b00, 0, 0, 0));
		i_enc_main.quad(1, 1'b1);
		rd(`EPC_OFF_COUNT, v + 32'h0000_0001);
		// clear on the main index, then on a one-cycle level, then capture
		wr(`EPC_OFF_CTRL, ctrl(2'b00, 0, 2, 0));
		i_enc_main.index();
		rd(`EPC_OFF_COUNT, 32'h0000_0000);
		i_enc_main.quad(n, 1'b1);
		wr(`EPC_OFF_CTRL, ctrl(2'b00, 0, 1, 1));
		c = clear_seen;
		clear_level <= 1'b1;
		@(posedge mclk);
		clear_level <= 1'b0;
		i_enc_main.quad(m + 1, 1'b1);
		rd(`EPC_OFF_COUNT, 32'(m + 1));
		check(32'(clear_seen - c), 32'h0000_0001);
		c = save_seen;
		save_level <= 1'b1;
		@(posedge mclk);
		save_level <= 1'b0;
		i_enc_main.quad(1, 1'b1);
		rd(`EPC_OFF_CAPTURED, 32'(m + 1));
		check(32'(save_seen - c), 32'h0000_0001);
		rd(`EPC_OFF_COUNT, 32'(m + 2));
		// restart value wraps the count to zero and flags the clear
		t = 3 + $urandom % 5;
		wr(`EPC_OFF_CTRL, ctrl(2'b10, 0, 1, 0));
		wr(`EPC_OFF_IRQ_CLR, 32'h0000_0007);
		wr(`EPC_OFF_RESTART, 32'(t));
		c = clear_seen;
		i_enc_main.quad(t + 2, 1'b1);
		rd(`EPC_OFF_COUNT, 32'h0000_0002);
		check(32'(clear_seen - c), 32'h0000_0001);
		apb(1'b0, `EPC_OFF_STATUS, 32'h0000_0000, v);
		check(v & 32'h0000_0002, 32'h0000_0002);
		wr(`EPC_OFF_RESTART, 32'h0000_0000);
		// aux encoder in pulse and direction mode, up then down
		n = 2 + $urandom % 8;
		m = 1 + $urandom % (n - 1);
		wr(`EPC_OFF_CTRL, ctrl(2'b10, 1, 1, 0));
		i_enc_aux.pulse(n, 1'b1);
		i_enc_aux.pulse(m, 1'b0);
		rd(`EPC_OFF_COUNT, 32'(n - m));
		// extended sources, each cleared by its own edge choice
		for (int k = 0; k < 6; k++) begin
			n = 1 + $urandom % 9;
			wr(`EPC_OFF_CTRL, ctrl(2'b10, 2 + k / 2, 1, 0));
			wr(`EPC_OFF_CTRL, ctrl(2'b00, 2 + k / 2, 3 + k, 0));
			if (k < 2)
				i_enc_quick.quad(n, 1'b1);
			else if (k < 4)
				i_enc_exp1.pulse(n, 1'b1);
			else
				i_enc_exp2.pulse(n, 1'b1);
			rd(`EPC_OFF_COUNT, 32'(n));
			if (k < 2)
				i_enc_quick.index();
			else if (k < 4)
				i_enc_exp1.index();
			else
				i_enc_exp2.index();
			rd(`EPC_OFF_COUNT, 32'h0000_0000);
		end
		// an expansion index edge must not clear the quick pair's count
		wr(`EPC_OFF_CTRL, ctrl(2'b00, 2, 5, 0));
		i_enc_quick.quad(2, 1'b1);
		i_enc_exp1.index();
		rd(`EPC_OFF_COUNT, 32'h0000_0002);
		summarize();
	end
endmodule : tb_top

`default_nettype wire
